// ==== tb/srq_host_model.sv ====
// Host controller model issuing mask commands
`default_nettype none
module srq_host_model
(
   // Command lines
   input  wire logic   clk_i,
   output logic        wr_o,
   output logic [15:0] val_o,
   output logic        rd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {wr_o, val_o, rd_o} = '0;
   // One-cycle pulse; value scrambled once released
   task automatic send(input logic w, input logic [15:0] v);
      @(negedge clk_i);
      {wr_o, val_o, rd_o} = {w, v, !w};
      @(negedge clk_i);
      {wr_o, val_o, rd_o} = {1'b0, ~v, 1'b0};
   endtask : send
endmodule : srq_host_model
`default_nettype wire

// ==== tb/test_srq_mask.sv ====
// Bench for the service request enable mask
`default_nettype none
module test_srq_mask;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rst_n_i = 0, wr, rd, rv, er, mss, srq;
   logic [7:0] st = 8'h00, rdat, q;
   logic [15:0] val, ec, eq;
   int num_errors = 0, n_tests = 0, cyc = 0, n_err = 0;
   always #5 clk_i = ~clk_i;
   srq_host_model srq_host_model_i (.clk_i(clk_i), .wr_o(wr),
      .val_o(val), .rd_o(rd));
   srq_mask srq_mask_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
      .wr_i(wr), .wr_val_i(val), .rd_i(rd), .status_i(st),
      .rd_valid_o(rv), .rd_data_o(rdat), .err_o(er), .err_code_o(ec),
      .mss_o(mss), .srq_o(srq));
   // Catch one-cycle answers; timeout cuts a hang
   always @(posedge clk_i)
   begin
      if (rv === 1'b1)
      begin
         q <= rdat;
      end
      if (er === 1'b1)
      begin
         eq <= ec;
         n_err++;
      end
      if (++cyc > 400)
      begin
         num_errors++;
         end_sim();
      end
   end
   task automatic go(input logic w, input logic [15:0] v);
      srq_host_model_i.send(w, v);
      repeat (3) @(negedge clk_i);
   endtask : go
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin num_errors++;
         $display("unexpected %0t %h %h", $time, g, e); end
   endtask : chk
   task automatic end_sim;
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   // Write, read back, masked and enabled conditions
   task automatic t_write;
      st = 8'h01;
      go(1, 16'd18);
      go(0, 16'h0000);
      chk({8'h00, q}, 16'h0012);
      chk({15'h0000, srq}, 16'h0000);
      st = 8'h10;
      go(0, 16'h0000);
      chk({15'h0000, mss}, 16'h0001);
      chk({15'h0000, srq}, 16'h0001);
      $display("test write done");
   endtask : t_write
   // Bit 6 ignored on write and in the summary
   task automatic t_bit6;
      st = 8'h40;
      go(1, 16'd255);
      go(0, 16'h0000);
      chk({8'h00, q}, 16'h00BF);
      chk({15'h0000, mss}, 16'h0000);
      st = 8'h80;
      go(0, 16'h0000);
      chk({15'h0000, mss}, 16'h0001);
      $display("test bit6 done");
   endtask : t_bit6
   // Too large and negative values are refused
   task automatic t_range;
      go(1, 16'd300);
      chk(n_err, 1);
      chk(eq, srq_mask_pkg::ERR_RANGE);
      go(1, 16'hFFFF);
      chk(n_err, 2);
      go(0, 16'h0000);
      chk({8'h00, q}, 16'h00BF);
      $display("test range done");
   endtask : t_range
   // Zero clears the mask and stops requests
   task automatic t_zero;
      st = 8'hFF;
      go(1, 16'h0000);
      go(0, 16'h0000);
      chk({15'h0000, mss}, 16'h0000);
      chk({15'h0000, srq}, 16'h0000);
      chk({8'h00, q}, 16'h0000);
      $display("test zero done");
   endtask : t_zero
   // Reset in mid-run clears a written mask
   task automatic t_reset;
      go(1, 16'd18);
      go(0, 16'h0000);
      chk({8'h00, q}, 16'h0012);
      rst_n_i = 0;
      repeat (2) @(negedge clk_i);
      rst_n_i = 1;
      go(0, 16'h0000);
      chk({8'h00, q}, 16'h0000);
      chk({15'h0000, srq}, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   initial
   begin
      repeat (2) @(negedge clk_i);
      rst_n_i = 1;
      go(0, 16'h0000);
      chk({8'h00, q}, 16'h0000);
      t_write();
      t_bit6();
      t_range();
      t_zero();
      t_reset();
      end_sim();
   end
endmodule : test_srq_mask
`default_nettype wire

// ==== verilog/srq_mask.sv ====
// Service request enable mask with write, query and summary logic
`default_nettype none
module srq_mask
(
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        ce_i,
   // Enable-write command
   input  wire logic        wr_i,
   input  wire logic [15:0] wr_val_i,
   // Enable-query command
   input  wire logic        rd_i,
   // Status byte from the lower groups
   input  wire logic [7:0]  status_i,
   // Query answer
   output logic             rd_valid_o,
   output logic [7:0]       rd_data_o,
   // Error report
   output logic             err_o,
   output logic [15:0]      err_code_o,
   // Summary and service request
   output logic             mss_o,
   output logic             srq_o
);

   ////////////////////////////////////////////////////////////////////////
   // Internal state and nets

   // Decoder to mask store carrier
   srq_mask_if link ();

   // Command sequencer
   srq_mask_pkg::cmd_state_t state_reg;
   srq_mask_pkg::cmd_state_t state_next;

   // Captured write value, kept whole so the range test sees the sign
   logic [15:0] val_reg;
   logic [15:0] val_next;

   // Query answer
   logic        rd_valid_reg;
   logic        rd_valid_next;
   logic [7:0]  rd_data_reg;
   logic [7:0]  rd_data_next;

   // Error report
   logic        err_reg;
   logic        err_next;
   logic [15:0] err_code_reg;
   logic [15:0] err_code_next;

   // Summary and service request
   logic        mss_reg;
   logic        mss_next;
   logic        srq_reg;
   logic        srq_next;

   // Decode helpers
   logic        out_of_range;
   logic        load_cmd;
   logic [7:0]  enabled_bits;

   ////////////////////////////////////////////////////////////////////////
   // Mask store

   // Store keeps bit 6 clear itself, so no path can set it
   srq_mask_store srq_mask_store_i
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .bus     (link.store)
   );

   // Write request towards the store
   assign link.load     = load_cmd;
   assign link.load_val = val_reg[7:0];

   ////////////////////////////////////////////////////////////////////////
   // Range check of the written value

   // Negative or above 255 is refused; the mask is left untouched
   always_comb
   begin
      out_of_range = 1'b0;
      if ($signed(val_reg) > srq_mask_pkg::VAL_MAX)
      begin
         out_of_range = 1'b1;
      end
      if ($signed(val_reg) < 16'sh0000)
      begin
         out_of_range = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer

   // One command at a time; requests while busy are ignored
   always_comb
   begin
      state_next    = state_reg;
      val_next      = val_reg;
      rd_valid_next = 1'b0;
      rd_data_next  = rd_data_reg;
      err_next      = 1'b0;
      err_code_next = err_code_reg;
      load_cmd      = 1'b0;
      unique case (state_reg)
         srq_mask_pkg::ST_IDLE:
         begin
            // Write wins when both strobes arrive together
            if (wr_i)
            begin
               val_next   = wr_val_i;
               state_next = srq_mask_pkg::ST_WRITE;
            end
            else if (rd_i)
            begin
               state_next = srq_mask_pkg::ST_QUERY;
            end
         end
         srq_mask_pkg::ST_WRITE:
         begin
            if (out_of_range)
            begin
               err_next      = 1'b1;
               err_code_next = srq_mask_pkg::ERR_RANGE;
            end
            else
            begin
               load_cmd = 1'b1;
            end
            state_next = srq_mask_pkg::ST_IDLE;
         end
         srq_mask_pkg::ST_QUERY:
         begin
            rd_valid_next = 1'b1;
            rd_data_next  = link.mask;
            state_next    = srq_mask_pkg::ST_IDLE;
         end
         default:
         begin
            // Unused code 10 falls back to idle
            state_next = srq_mask_pkg::ST_IDLE;
         end
      endcase
   end

   // Register only; clock enable freezes everything
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg    <= srq_mask_pkg::ST_IDLE;
         val_reg      <= srq_mask_pkg::VAL_RESET;
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= srq_mask_pkg::DATA_RESET;
         err_reg      <= 1'b0;
         err_code_reg <= srq_mask_pkg::ERR_CODE_RESET;
      end
      else if (ce_i)
      begin
         state_reg    <= state_next;
         val_reg      <= val_next;
         rd_valid_reg <= rd_valid_next;
         rd_data_reg  <= rd_data_next;
         err_reg      <= err_next;
         err_code_reg <= err_code_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Summary of enabled status bits

   // Per-bit gate; bit 6 is masked twice on purpose
   for (genvar b = 0; b < srq_mask_pkg::MASK_W; b++)
   begin : g_enable
      assign enabled_bits[b] = status_i[b] & link.mask[b]
                               & srq_mask_pkg::MASK_USED[b];
   end

   // Request follows the summary; no poll clear in this block
   always_comb
   begin
      mss_next = |enabled_bits;
      srq_next = |enabled_bits;
   end

   // Register only
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mss_reg <= 1'b0;
         srq_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         mss_reg <= mss_next;
         srq_reg <= srq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flip-flops

   assign rd_valid_o = rd_valid_reg;
   assign rd_data_o  = rd_data_reg;
   assign err_o      = err_reg;
   assign err_code_o = err_code_reg;
   assign mss_o      = mss_reg;
   assign srq_o      = srq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   // Summary is the gated OR of the previous cycle
   chk_summary_formula: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      $past(ce_i) |-> mss_o == $past(|enabled_bits))
      else $error("summary differs from gated status");

   // No request without an enabled condition
   chk_srq_masked: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      ($past(ce_i) && !$past(|enabled_bits)) |-> !srq_o)
      else $error("request without enabled condition");

   // A cleared mask gives no request
   chk_zero_mask: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      (ce_i && link.mask == 8'h00) |=> !srq_o)
      else $error("request with cleared mask");

   // Accepted write replaces the mask
   chk_write_load: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      (ce_i && state_reg == srq_mask_pkg::ST_WRITE && !out_of_range)
      |=> link.mask == ($past(val_reg[7:0]) & srq_mask_pkg::MASK_USED))
      else $error("write did not load the mask");

   // Refused write reports the range error
   chk_range_error: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      (ce_i && state_reg == srq_mask_pkg::ST_WRITE && out_of_range)
      |=> (err_o && err_code_o == srq_mask_pkg::ERR_RANGE))
      else $error("range error not reported");

   // Refused write leaves the mask alone
   chk_range_keep: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      (ce_i && state_reg == srq_mask_pkg::ST_WRITE && out_of_range)
      |=> $stable(link.mask))
      else $error("refused write changed the mask");

   // Query answer equals the stored mask
   chk_query_data: assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      rd_valid_o |-> rd_data_o == link.mask)
      else $error("query answer differs from mask");

   ////////////////////////////////////////////////////////////////////////
   // Cover points

   cov_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      load_cmd && ce_i);
   cov_query: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      rd_valid_o);
   cov_error: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      err_o);
   cov_request: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      srq_o);
endmodule : srq_mask
`default_nettype wire

// ==== verilog/srq_mask_if.sv ====
// Interface between the command decoder and the mask store
`default_nettype none
interface srq_mask_if;
   logic       load;
   logic [7:0] load_val;
   logic [7:0] mask;

   modport ctrl  (output load, output load_val, input mask);
   modport store (input load, input load_val, output mask);
endinterface : srq_mask_if
`default_nettype wire

// ==== verilog/srq_mask_pkg.sv ====
// Constants and types for the service request enable mask
// Summary of operation
// - Enable-write loads mask bits 0-5 and 7, replacing old contents.
// - Service request raised only for status conditions whose mask bit is set.
// - Bit 6 (weight 64) of a written value is ignored.
// - Values below 0 or above 255 rejected with error -222.
// - Writing zero clears the mask; no requests until a value with one of bits 0-5,7 set is accepted.
// - Summary is OR over bits 0-5,7 of status AND mask.
// - Enable-query returns the current mask as integer 0 to 63 or 128 to 191.
`default_nettype none
package srq_mask_pkg;
   localparam int                 MASK_W        = 8;
   localparam int                 VAL_W         = 16;
   localparam int                 MSS_BIT       = 6;
   localparam logic [7:0]         MASK_RESET    = 8'h00;
   localparam logic [7:0]         MASK_USED     = 8'hBF;
   localparam logic signed [15:0] VAL_MAX       = 16'sh00FF;
   localparam logic signed [15:0] ERR_RANGE    = -16'sh00DE;
   localparam logic [15:0]        VAL_RESET     = 16'h0000;
   localparam logic [15:0]        ERR_CODE_RESET = 16'h0000;
   localparam logic [7:0]         DATA_RESET    = 8'h00;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_WRITE = 2'b01,
      ST_QUERY = 2'b11
   } cmd_state_t;
endpackage : srq_mask_pkg
`default_nettype wire

// ==== verilog/srq_mask_store.sv ====
// Mask store holding enable bits 0-5 and 7
`default_nettype none
module srq_mask_store
(
   // Clock and control
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   input  wire logic   ce_i,
   // Link to the decoder
   srq_mask_if.store   bus
);
   logic [7:0] mask_reg;
   logic [7:0] mask_next;

   // Bit 6 is never stored, so it cannot leak into the summary
   always_comb
   begin
      mask_next = mask_reg;
      if (bus.load)
      begin
         mask_next = bus.load_val & srq_mask_pkg::MASK_USED;
      end
   end

   // Register only
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mask_reg <= srq_mask_pkg::MASK_RESET;
      end
      else if (ce_i)
      begin
         mask_reg <= mask_next;
      end
   end

   assign bus.mask = mask_reg;

   chk_bit6_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      mask_reg[srq_mask_pkg::MSS_BIT] == 1'b0)
      else $error("mask bit 6 set");
endmodule : srq_mask_store
`default_nettype wire
